// ---- fault_mon_defines.svh ----
`ifndef FAULT_MON_DEFINES_SVH
`define FAULT_MON_DEFINES_SVH

// ----------------------------------------------------------------------
// detection thresholds and fault codes
// ----------------------------------------------------------------------
`define DEV_LIMIT      32'h2000_0000
`define MAIN_NONE      8'h00
`define MAIN_DEV       8'h1D
`define MAIN_SAFE      8'h1E
`define MAIN_ASG       8'h21
`define MAIN_SOFT      8'h22
`define SUB_ZERO       8'h00

// ----------------------------------------------------------------------
// function numbers of the input and output assignment maps
// ----------------------------------------------------------------------
`define FN_NONE        8'h00
`define FN_CL          8'h0D
`define FN_INH         8'h0E
`define IN_FN_MAX      8'h27
`define OUT_FN_MAX     8'h1F
`define IN_CL_IDX      6
`define IN_INH_IDX     9
`define IN_COUNT       10
`define OUT_COUNT      6

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_CTRL       8'h00
`define OFS_RANGE      8'h04
`define OFS_IN_MAP_A   8'h08
`define OFS_IN_MAP_B   8'h0C
`define OFS_IN_MAP_C   8'h10
`define OFS_OUT_MAP_A  8'h14
`define OFS_OUT_MAP_B  8'h18
`define OFS_FAULT      8'h1C
`define OFS_STATUS     8'h20
`define OFS_MASK       8'h24

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define CTRL_CLR_BIT   0
`define FAULT_ACT_BIT  16
`define FAULT_LOCK_BIT 17
`define EV_DEV         0
`define EV_SAFE        1
`define EV_ASG         2
`define EV_SOFT        3
`define EV_CLR         4
`define EV_W           5
`define RANGE_RST      32'h0000_0000
`define MASK_RST       5'h00
`define STATUS_RST     5'h00

`endif

// ---- fault_mon_pkg.sv ----
`default_nettype none

package fault_mon_pkg;
  typedef logic [7:0]  fn_t;
  typedef logic [7:0]  code_t;
  typedef logic [31:0] word_t;
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_TRIP = 3'b010,
    ST_LOCK = 3'b100
  } fstate_t;
endpackage : fault_mon_pkg

`default_nettype wire

// ---- io_map_check.sv ----
`include "fault_mon_defines.svh"
`default_nettype none

module io_map_check (
  input  wire fault_mon_pkg::fn_t in_map  [10],
  input  wire fault_mon_pkg::fn_t out_map [6],
  output logic [7:0]              asg_flags
);
  import fault_mon_pkg::*;

  // ----------------------------------------------------------------------
  // checks over one group of five inputs or three outputs
  // ----------------------------------------------------------------------
  function automatic logic grp_dup(input fn_t m [10], input int base);
    logic hit;
    hit = 1'b0;
    for (int i = base; i < base + 5; i++) begin
      for (int j = i + 1; j < base + 5; j++) begin
        if (m[i] != `FN_NONE && m[i] == m[j]) begin
          hit = 1'b1;
        end
      end
    end
    return hit;
  endfunction : grp_dup

  function automatic logic in_undef(input fn_t m [10], input int base);
    logic hit;
    hit = 1'b0;
    for (int i = base; i < base + 5; i++) begin
      if (m[i] > `IN_FN_MAX) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : in_undef

  function automatic logic out_undef(input fn_t m [6], input int base);
    logic hit;
    hit = 1'b0;
    for (int i = base; i < base + 3; i++) begin
      if (m[i] > `OUT_FN_MAX) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : out_undef

  // function found on any input except the one allowed to carry it
  function automatic logic misplaced(input fn_t m [10], input fn_t fn, input int keep);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `IN_COUNT; i++) begin
      if (i != keep && m[i] == fn) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : misplaced

  // ----------------------------------------------------------------------
  // flag index equals the sub code
  // ----------------------------------------------------------------------
  assign asg_flags[0] = grp_dup(in_map, 0);
  assign asg_flags[1] = grp_dup(in_map, 5);
  assign asg_flags[2] = in_undef(in_map, 0);
  assign asg_flags[3] = in_undef(in_map, 5);
  assign asg_flags[4] = out_undef(out_map, 0);
  assign asg_flags[5] = out_undef(out_map, 3);
  assign asg_flags[6] = misplaced(in_map, `FN_CL, `IN_CL_IDX);
  assign asg_flags[7] = misplaced(in_map, `FN_INH, `IN_INH_IDX);

endmodule : io_map_check

`default_nettype wire

// ---- servo_fault_protection_monitor.sv ----
// Notes on behaviour
// - deviation beyond 536870912 pulses trips 29/0
// - either safety input off trips 30/0
// - duplicate function on inputs one-five: 33/0
// - duplicate function on inputs six-ten: 33/1
// - undefined function on inputs one-five: 33/2
// - undefined function on inputs six-ten: 33/3
// - undefined function on outputs one-three: 33/4
// - undefined function on outputs four-six: 33/5
// - counter clear off input seven: 33/6
// - pulse inhibit off input ten: 33/7
// - position outside travel range trips 34/0
// - travel range zero disables that check
// - code 33 ignores clear until power cycle
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`include "fault_mon_defines.svh"
`default_nettype none

module servo_fault_protection_monitor (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire fault_mon_pkg::word_t deviation_count,
  input  wire logic                 safety_input_one,
  input  wire logic                 safety_input_two,
  input  wire logic                 alarm_clear_input,
  input  wire fault_mon_pkg::word_t motor_position,
  input  wire logic                 position_cmd_valid,
  input  wire logic [7:0]           reg_addr,
  input  wire fault_mon_pkg::word_t reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output fault_mon_pkg::word_t      reg_rdata,
  output logic                      fault_active,
  output logic                      fault_locked,
  output fault_mon_pkg::code_t      fault_main,
  output fault_mon_pkg::code_t      fault_sub,
  output logic                      irq
);
  import fault_mon_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic word_t mag(input word_t v);
    return v[31] ? word_t'(~v + 32'h0000_0001) : v;
  endfunction : mag

  // index of the lowest set flag
  function automatic code_t first_set(input logic [7:0] f);
    code_t idx;
    idx = `SUB_ZERO;
    for (int i = 7; i >= 0; i--) begin
      if (f[i]) begin
        idx = code_t'(i);
      end
    end
    return idx;
  endfunction : first_set

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  // async assert, released two edges after rst_n rises
  logic [1:0] rst_sync_r;
  logic       rst_s_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_s_n = rst_sync_r[1];

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  word_t        range_r;
  fn_t          in_map_r  [10];
  fn_t          out_map_r [6];
  logic [4:0]   status_r;
  logic [4:0]   status_nxt;
  logic [4:0]   mask_r;
  word_t        rdata_r;
  logic         acl_q_r;
  fstate_t      state_r;
  fstate_t      state_nxt;
  code_t        main_r;
  code_t        main_nxt;
  code_t        sub_r;
  code_t        sub_nxt;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  wire wr_ctrl   = reg_wr && reg_addr == `OFS_CTRL;
  wire wr_range  = reg_wr && reg_addr == `OFS_RANGE;
  wire wr_in_a   = reg_wr && reg_addr == `OFS_IN_MAP_A;
  wire wr_in_b   = reg_wr && reg_addr == `OFS_IN_MAP_B;
  wire wr_in_c   = reg_wr && reg_addr == `OFS_IN_MAP_C;
  wire wr_out_a  = reg_wr && reg_addr == `OFS_OUT_MAP_A;
  wire wr_out_b  = reg_wr && reg_addr == `OFS_OUT_MAP_B;
  wire wr_status = reg_wr && reg_addr == `OFS_STATUS;
  wire wr_mask   = reg_wr && reg_addr == `OFS_MASK;

  wire [4:0] w1c = wr_status ? reg_wdata[4:0] : 5'h00;

  // ----------------------------------------------------------------------
  // detection
  // ----------------------------------------------------------------------
  logic [7:0] asg_flags;

  // assignment checks are pure decode of the maps
  io_map_check u_map_check (
    .in_map    (in_map_r),
    .out_map   (out_map_r),
    .asg_flags (asg_flags)
  );

  wire trip_dev  = mag(deviation_count) > `DEV_LIMIT;
  wire trip_safe = !safety_input_one || !safety_input_two;
  wire asg_any   = |asg_flags;
  wire soft_on   = range_r != `RANGE_RST;
  wire trip_soft = soft_on && position_cmd_valid
                   && mag(motor_position) > range_r;
  wire det_any   = trip_dev || trip_safe || asg_any || trip_soft;

  // non-clearable faults take precedence so they are never masked
  wire code_t det_main = asg_any   ? `MAIN_ASG  :
                         trip_dev  ? `MAIN_DEV  :
                         trip_safe ? `MAIN_SAFE :
                         trip_soft ? `MAIN_SOFT : `MAIN_NONE;
  wire code_t det_sub  = asg_any ? first_set(asg_flags) : `SUB_ZERO;

  // ----------------------------------------------------------------------
  // clear requests
  // ----------------------------------------------------------------------
  // clear acts only on a clearable held fault
  wire acl_rise  = alarm_clear_input && !acl_q_r;
  wire clear_req = acl_rise || (wr_ctrl && reg_wdata[`CTRL_CLR_BIT]);

  // ----------------------------------------------------------------------
  // fault state machine
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    main_nxt  = main_r;
    sub_nxt   = sub_r;
    case (state_r)
      ST_RUN: begin
        if (det_any) begin
          main_nxt  = det_main;
          sub_nxt   = det_sub;
          state_nxt = asg_any ? ST_LOCK : ST_TRIP;
        end
      end
      ST_TRIP: begin
        if (clear_req) begin
          main_nxt  = `MAIN_NONE;
          sub_nxt   = `SUB_ZERO;
          state_nxt = ST_RUN;
        end
      end
      // only a power cycle leaves the locked state
      ST_LOCK: begin
        state_nxt = ST_LOCK;
      end
      default: begin
        state_nxt = ST_RUN;
        main_nxt  = `MAIN_NONE;
        sub_nxt   = `SUB_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state_r <= ST_RUN;
      main_r  <= `MAIN_NONE;
      sub_r   <= `SUB_ZERO;
      acl_q_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      main_r  <= main_nxt;
      sub_r   <= sub_nxt;
      acl_q_r <= alarm_clear_input;
    end
  end

  // ----------------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------------
  // one bit per latched cause, bit four per clear
  wire latch_ev = state_r == ST_RUN && det_any;
  wire clr_ev   = state_r == ST_TRIP && clear_req;

  wire [4:0] ev_vec = {clr_ev,
                       latch_ev && det_main == `MAIN_SOFT,
                       latch_ev && det_main == `MAIN_ASG,
                       latch_ev && det_main == `MAIN_SAFE,
                       latch_ev && det_main == `MAIN_DEV};

  // set wins over a write-one clear in the same cycle
  assign status_nxt = (status_r & ~w1c) | ev_vec;

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      status_r <= `STATUS_RST;
      mask_r   <= `MASK_RST;
    end else if (clk_en) begin
      status_r <= status_nxt;
      if (wr_mask) begin
        mask_r <= reg_wdata[4:0];
      end
    end
  end

  // level interrupt, no edge memory of its own
  assign irq = |(status_r & mask_r);

  // ----------------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------------
  // map writes carry four bytes, lowest index first
  wire [3:0] in_base  = wr_in_a ? 4'h0 : wr_in_b ? 4'h4 : 4'h8;
  wire       in_wr    = wr_in_a || wr_in_b || wr_in_c;
  wire [2:0] out_base = wr_out_a ? 3'h0 : 3'h4;
  wire       out_wr   = wr_out_a || wr_out_b;

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      range_r <= `RANGE_RST;
      for (int i = 0; i < `IN_COUNT; i++) begin
        in_map_r[i] <= `FN_NONE;
      end
      in_map_r[`IN_CL_IDX]  <= `FN_CL;
      in_map_r[`IN_INH_IDX] <= `FN_INH;
      for (int i = 0; i < `OUT_COUNT; i++) begin
        out_map_r[i] <= `FN_NONE;
      end
    end else if (clk_en) begin
      if (wr_range) begin
        range_r <= reg_wdata;
      end
      // bytes past the last index are dropped
      for (int k = 0; k < 4; k++) begin
        if (in_wr && int'(in_base) + k < `IN_COUNT) begin
          in_map_r[int'(in_base) + k] <= reg_wdata[8*k +: 8];
        end
        if (out_wr && int'(out_base) + k < `OUT_COUNT) begin
          out_map_r[int'(out_base) + k] <= reg_wdata[8*k +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  wire word_t in_a_val  = {in_map_r[3], in_map_r[2], in_map_r[1], in_map_r[0]};
  wire word_t in_b_val  = {in_map_r[7], in_map_r[6], in_map_r[5], in_map_r[4]};
  wire word_t in_c_val  = {16'h0000, in_map_r[9], in_map_r[8]};
  wire word_t out_a_val = {out_map_r[3], out_map_r[2], out_map_r[1], out_map_r[0]};
  wire word_t out_b_val = {16'h0000, out_map_r[5], out_map_r[4]};
  wire word_t fault_val = {14'h0000, state_r == ST_LOCK, state_r != ST_RUN,
                           main_r, sub_r};

  // unmapped offsets read as zero
  wire word_t rd_val =
    reg_addr == `OFS_RANGE     ? range_r   :
    reg_addr == `OFS_IN_MAP_A  ? in_a_val  :
    reg_addr == `OFS_IN_MAP_B  ? in_b_val  :
    reg_addr == `OFS_IN_MAP_C  ? in_c_val  :
    reg_addr == `OFS_OUT_MAP_A ? out_a_val :
    reg_addr == `OFS_OUT_MAP_B ? out_b_val :
    reg_addr == `OFS_FAULT     ? fault_val :
    reg_addr == `OFS_STATUS    ? {27'h0000000, status_r} :
    reg_addr == `OFS_MASK      ? {27'h0000000, mask_r}   : 32'h0000_0000;

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_r <= reg_rd ? rd_val : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // status outputs decoded from the state register
  assign reg_rdata    = rdata_r;
  assign fault_active = state_r != ST_RUN;
  assign fault_locked = state_r == ST_LOCK;
  assign fault_main   = main_r;
  assign fault_sub    = sub_r;

endmodule : servo_fault_protection_monitor

`default_nettype wire

// ---- fault_mon_props.sv ----
`default_nettype none

module fault_mon_props (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire fault_mon_pkg::word_t deviation_count,
  input  wire logic                 safety_input_one,
  input  wire logic                 safety_input_two,
  input  wire logic                 alarm_clear_input,
  input  wire logic                 reg_rd,
  input  wire fault_mon_pkg::word_t reg_rdata,
  input  wire logic                 fault_active,
  input  wire logic                 fault_locked,
  input  wire fault_mon_pkg::code_t fault_main,
  input  wire fault_mon_pkg::code_t fault_sub
);
  timeunit 1ns;
  timeprecision 1ps;
  import fault_mon_pkg::*;
  logic [2:0] rst_q_r;
  logic       run_ok;
  logic       dev_big;
  // ----------------------------------------------------------------------
  // released three edges after rst_n rises, one edge after the design's reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rst_q_r <= 3'h0;
    else rst_q_r <= {rst_q_r[1:0], 1'b1};
  end
  assign run_ok  = rst_q_r[2];
  assign dev_big = ($signed(deviation_count) > 32'sh2000_0000) ||
                   ($signed(deviation_count) < -32'sh2000_0000);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!run_ok);
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  chk_dev_trip: assert property (clk_en && !fault_active && dev_big |=> fault_active &&
    (fault_main == 8'h1D || fault_main == 8'h21)) else $error("deviation trip missing");
  chk_safe_trip: assert property (clk_en && !fault_active &&
    !(safety_input_one && safety_input_two) |=> fault_active &&
    fault_main inside {8'h1D, 8'h1E, 8'h21}) else $error("safety trip missing");
  chk_lock_code: assert property (fault_locked |-> fault_active &&
    fault_main == 8'h21 && fault_sub <= 8'h07) else $error("locked code wrong");
  chk_lock_hold: assert property (fault_locked |=> fault_locked &&
    $stable(fault_sub)) else $error("lock released");
  chk_lock_ignore: assert property (fault_locked && alarm_clear_input |=>
    fault_active) else $error("locked fault cleared");
  chk_clear_trip: assert property (clk_en && $past(clk_en) && fault_active &&
    !fault_locked && alarm_clear_input && !$past(alarm_clear_input) |=> !fault_active)
    else $error("clear ignored");
  chk_code_hold: assert property (fault_active && $past(fault_active) |->
    $stable(fault_main) && $stable(fault_sub)) else $error("latched code moved");
  chk_idle_zero: assert property (!fault_active |-> fault_main == 8'h00 &&
    fault_sub == 8'h00) else $error("code without fault");
  chk_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |->
    reg_rdata == 32'h0000_0000) else $error("read data outside slot");
  cover property (fault_active && fault_main == 8'h1D);
  cover property (fault_locked);
  cover property (fault_active ##1 !fault_active);
endmodule : fault_mon_props

bind servo_fault_protection_monitor fault_mon_props i_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .deviation_count(deviation_count),
  .safety_input_one(safety_input_one), .safety_input_two(safety_input_two),
  .alarm_clear_input(alarm_clear_input), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .fault_active(fault_active), .fault_locked(fault_locked), .fault_main(fault_main),
  .fault_sub(fault_sub));

`default_nettype wire

// ---- host_ctrl_model.sv ----
`default_nettype none

module host_ctrl_model (
  input  wire logic                 clk_sys,
  input  wire logic [1:0]           want_safe,
  input  wire logic                 want_clr,
  input  wire fault_mon_pkg::word_t want_dev,
  input  wire fault_mon_pkg::word_t want_pos,
  input  wire logic                 want_valid,
  output var  logic                 safety_input_one,
  output var  logic                 safety_input_two,
  output var  logic                 alarm_clear_input,
  output var  fault_mon_pkg::word_t deviation_count,
  output var  fault_mon_pkg::word_t motor_position,
  output var  logic                 position_cmd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import fault_mon_pkg::*;
  // ----------------------------------------------------------------------
  // host update tick: requests reach the pins one clock later
  // ----------------------------------------------------------------------
  always @(posedge clk_sys) begin
    safety_input_one   <= want_safe[0];
    safety_input_two   <= want_safe[1];
    alarm_clear_input  <= want_clr;
    deviation_count    <= want_dev;
    motor_position     <= want_pos;
    position_cmd_valid <= want_valid;
  end
endmodule : host_ctrl_model

`default_nettype wire

// ---- testbench.sv ----
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fault_mon_pkg::*;
  logic       clk_sys, rst_n, clk_en, reg_wr, reg_rd, irq, f_act, f_lock, s1, s2, aclr, pv;
  logic       w_clr, w_valid;
  logic [1:0] w_safe;
  logic [7:0] reg_addr;
  word_t      w_dev, w_pos, dev, pos, reg_wdata, reg_rdata, rdat, d, p, r;
  code_t      f_main, f_sub;
  int         n_fail, check_count, seed, k;
  logic [7:0] asg_addr [8] = '{8'h08, 8'h0C, 8'h08, 8'h10, 8'h14, 8'h18, 8'h08, 8'h08};
  word_t      asg_data [8] = '{32'h0000_0505, 32'h050D_0500, 32'h0000_0028, 32'h0000_0E28,
                               32'h0000_0020, 32'h0000_0020, 32'h0000_000D, 32'h0000_000E};
  word_t      dev_bnd [4] = '{32'h2000_0000, 32'h2000_0001, 32'hDFFF_FFFF, 32'hE000_0000};

  host_ctrl_model i_host (.clk_sys(clk_sys), .want_safe(w_safe), .want_clr(w_clr),
    .want_dev(w_dev), .want_pos(w_pos), .want_valid(w_valid), .safety_input_one(s1),
    .safety_input_two(s2), .alarm_clear_input(aclr), .deviation_count(dev),
    .motor_position(pos), .position_cmd_valid(pv));
  servo_fault_protection_monitor i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .deviation_count(dev), .safety_input_one(s1), .safety_input_two(s2),
    .alarm_clear_input(aclr), .motor_position(pos), .position_cmd_valid(pv),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fault_active(f_act), .fault_locked(f_lock),
    .fault_main(f_main), .fault_sub(f_sub), .irq(irq));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------------
  function automatic logic exp_dev(word_t x);
    return ($signed(x) > 32'sh2000_0000) || ($signed(x) < -32'sh2000_0000);
  endfunction : exp_dev
  function automatic logic exp_soft(word_t rg, word_t ps, logic v);
    word_t mag;
    mag = ps[31] ? -ps : ps;
    return v && (rg != 32'h0) && (mag > rg);
  endfunction : exp_soft
  // ----------------------------------------------------------------------
  // checks and bus cycles
  // ----------------------------------------------------------------------
  task automatic stop_test();
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic cmp_w(string nm, word_t e, word_t g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask : cmp_w
  task automatic cmp_b(string nm, logic e, logic g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s exp %b got %b", nm, e, g);
      n_fail++;
    end
  endtask : cmp_b
  task automatic wr(logic [7:0] a, word_t v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, output word_t v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : do_reset
  task automatic wait_act(logic e);
    int i;
    for (i = 0; i < 10 && f_act !== e; i++) begin
      @(posedge clk_sys);
      #1;
    end
    cmp_b("fault_active_wait", e, f_act);
    if (f_act !== e) stop_test();
  endtask : wait_act
  task automatic chk_fault(code_t m, code_t s, logic a, logic l);
    rd(8'h1C, rdat);
    cmp_w("fault_word", {14'h0, l, a, m, s}, rdat);
    cmp_w("fault_pins", {14'h0, l, a, m, s}, {14'h0, f_lock, f_act, f_main, f_sub});
  endtask : chk_fault
  task automatic clear_fault();
    w_clr <= 1'b1;
    repeat (3) @(posedge clk_sys);
    w_clr <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : clear_fault
  task automatic run_case(logic [1:0] sf, word_t dv, word_t ps, logic v, logic e, code_t m);
    @(posedge clk_sys);
    w_safe <= sf;
    w_dev  <= dv;
    w_pos  <= ps;
    w_valid <= v;
    if (e) begin
      wait_act(1'b1);
      chk_fault(m, 8'h00, 1'b1, 1'b0);
    end else begin
      repeat (4) @(posedge clk_sys);
      #1 cmp_b("fault_active", 1'b0, f_act);
    end
    @(posedge clk_sys);
    w_safe  <= 2'b11;
    w_dev   <= 32'h0000_0000;
    w_valid <= 1'b0;
    clear_fault();
    wait_act(1'b0);
  endtask : run_case
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    n_fail = 0; check_count = 0; rst_n = 1'b0; clk_en = 1'b1; reg_wr = 1'b0;
    reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; w_safe = 2'b11; w_clr = 1'b0;
    w_dev = 32'h0; w_pos = 32'h0; w_valid = 1'b0;
    seed = $urandom(32'hC7BE);
    do_reset();
    rd(8'h0C, rdat); cmp_w("in_map_b", 32'h000D_0000, rdat);
    rd(8'h10, rdat); cmp_w("in_map_c", 32'h0000_0E00, rdat);
    rd(8'h04, rdat); cmp_w("range", 32'h0000_0000, rdat);
    rd(8'hFC, rdat); cmp_w("unmapped", 32'h0000_0000, rdat);
    chk_fault(8'h00, 8'h00, 1'b0, 1'b0);
    wr(8'h24, 32'h0000_001F);
    for (k = 0; k < 3; k++) run_case(k[1:0], 32'h0, 32'h0, 1'b0, 1'b1, 8'h1E);
    rd(8'h20, rdat); cmp_w("status", 32'h0000_0012, rdat);
    cmp_b("irq_set", 1'b1, irq);
    @(posedge clk_sys);
    w_safe <= 2'b01;
    wait_act(1'b1);
    w_safe <= 2'b11;
    repeat (2) @(posedge clk_sys);
    wr(8'h00, 32'h0000_0001);
    wait_act(1'b0);
    wr(8'h20, 32'h0000_001F);
    rd(8'h20, rdat); cmp_w("status_w1c", 32'h0000_0000, rdat);
    cmp_b("irq_clr", 1'b0, irq);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    w_safe <= 2'b00;
    repeat (3) @(posedge clk_sys);
    w_safe <= 2'b11;
    repeat (3) @(posedge clk_sys);
    clk_en <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 cmp_b("frozen", 1'b0, f_act);
    wr(8'h24, 32'h0000_0001);
    for (k = 0; k < 10; k++) begin
      d = dev_bnd[k % 4];
      if (k >= 4) d = $urandom_range(32'h2000_00FF, 32'h1FFF_FF00);
      if (k >= 4 && $urandom_range(1, 0) == 1) d = -d;
      run_case(2'b11, d, 32'h0, 1'b0, exp_dev(d), 8'h1D);
    end
    rd(8'h20, rdat); cmp_w("status_dev", 32'h0000_0011, rdat);
    cmp_b("irq_dev", 1'b1, irq);
    wr(8'h24, 32'h0000_0002);
    rd(8'h24, rdat);
    cmp_w("mask", 32'h0000_0002, rdat);
    cmp_b("irq_masked", 1'b0, irq);
    run_case(2'b11, 32'h0, 32'h7FFF_FFFF, 1'b1, 1'b0, 8'h22);
    for (k = 0; k < 8; k++) begin
      r = $urandom_range(1000, 1);
      p = (k == 0) ? r + 1 : (k == 1) ? r : $urandom_range(2000, 0);
      if (k >= 2 && $urandom_range(1, 0) == 1) p = -p;
      wr(8'h04, r);
      run_case(2'b11, 32'h0, p, k < 2 || k[0], exp_soft(r, p, k < 2 || k[0]), 8'h22);
    end
    rd(8'h20, rdat);
    cmp_w("status_soft", 32'h0000_0019, rdat);
    for (k = 0; k < 8; k++) begin
      do_reset();
      wr(asg_addr[k], asg_data[k]);
      wait_act(1'b1);
      chk_fault(8'h21, k[7:0], 1'b1, 1'b1);
      rd(8'h20, rdat);
      cmp_w("status_asg", 32'h0000_0004, rdat);
      clear_fault();
      wr(8'h00, 32'h0000_0001);
      chk_fault(8'h21, k[7:0], 1'b1, 1'b1);
    end
    do_reset();
    chk_fault(8'h00, 8'h00, 1'b0, 1'b0);
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end
endmodule : testbench

`default_nettype wire
